// *** rtl/swm_flag_bank.sv ***
// Sticky status flags: hardware set, software clear, set wins
`timescale 1ns/10ps
`default_nettype none
module swm_flag_bank
  import swm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_FLAGS-1:0] set_pulse,
  input wire logic [NUM_FLAGS-1:0] clr_pulse,
  output logic [NUM_FLAGS-1:0] flags
);

  logic [NUM_FLAGS-1:0] flags_ff;
  logic [NUM_FLAGS-1:0] nxt_flags;

  // Clear first, then set, so a simultaneous event is kept
  always_comb begin
    nxt_flags = (flags_ff & ~clr_pulse) | set_pulse;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= RST_FLAGS;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule // swm_flag_bank
`default_nettype wire

// *** rtl/swm_frame_len.sv ***
// Holder for the payload byte count of the last received frame
`timescale 1ns/10ps
`default_nettype none
module swm_frame_len
  import swm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_done,
  input wire logic [FLEN_W-1:0] frame_bytes,
  output logic [FLEN_W-1:0] byte_count
);

  logic [FLEN_W-1:0] count_ff;
  logic [FLEN_W-1:0] nxt_count;

  // Loaded at the end of each received frame, held otherwise
  always_comb begin
    nxt_count = count_ff;
    if (frame_done) begin
      nxt_count = frame_bytes;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff <= RST_FRAME_LEN[FLEN_MSB:FLEN_LSB];
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign byte_count = count_ff;

endmodule // swm_frame_len
`default_nettype wire

// *** rtl/swm_irq_frame.sv ***
// Interrupt enables, sticky status flags, interrupt output and received frame length register
//
// Summary of operation
// R1 - Enable bit 6 lets the transmit-data-empty flag raise the interrupt.
// R2 - Enable bit 5 lets the receive-data-ready flag raise the interrupt.
// R3 - Enable bit 4 lets the transmit underrun flag raise the interrupt.
// R4 - Enable bit 3 lets the receive overrun flag raise the interrupt.
// R5 - Enable bit 2 lets the receive CRC error flag raise the interrupt.
// R6 - Enable bit 1 lets the transmit buffer empty flag raise the interrupt.
// R7 - Enable bit 0 lets the receive buffer full flag raise the interrupt.
// R8 - A zero enable masks its flag's interrupt but leaves the flag alone.
// R9 - Bits 4:0 of the frame length register give last frame payload bytes.
// R10 - Length bits 1:0 tell how many bytes of the last data read are valid.
// R11 - Frame length register resets to zero; bits 31:5 reserved, read as zero.
// R12 - Interrupt is OR of flags ANDed with enables, held while any stays set.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module swm_irq_frame
  import swm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Event pulses from the link logic
  input wire logic ev_tx_data_empty,
  input wire logic ev_rx_data_ready,
  input wire logic ev_tx_underrun,
  input wire logic ev_rx_overrun,
  input wire logic ev_rx_crc_error,
  input wire logic ev_tx_buffer_empty,
  input wire logic ev_rx_buffer_full,
  // End of a received frame with its payload byte count
  input wire logic rx_frame_done,
  input wire logic [FLEN_W-1:0] rx_frame_bytes,
  // Interrupt and frame information
  output logic irq,
  output logic [VBYTES_W-1:0] rx_last_word_bytes
);

  // Address match helper, used for every register
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    addr_is = (addr == off);
  endfunction

  // Valid bytes in the final data word for a given payload length
  function automatic logic [VBYTES_W-1:0] tail_bytes(input logic [FLEN_W-1:0] len);
    logic [VBYTES_W-1:0] tb;
    tb = {1'b0, len[FLEN_TAIL_MSB:0]};
    if (len[FLEN_TAIL_MSB:0] == 2'b00) begin
      tb = (len == '0) ? '0 : FULL_WORD_BYTES;
    end
    tail_bytes = tb;
  endfunction

  // Bus decode
  logic wr_enable;
  logic wr_clear;
  logic rd_any;

  always_comb begin
    wr_enable = reg_wr && addr_is(reg_addr, OFF_ENABLE);
    wr_clear = reg_wr && addr_is(reg_addr, OFF_CLEAR);
    rd_any = reg_rd;
  end

  // Enable register
  logic [NUM_FLAGS-1:0] enable_ff;
  logic [NUM_FLAGS-1:0] nxt_enable;

  always_comb begin
    nxt_enable = enable_ff;
    if (wr_enable) begin
      nxt_enable = reg_wdata[NUM_FLAGS-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_ff <= RST_ENABLE;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // Status flags
  logic [NUM_FLAGS-1:0] set_vec;
  logic [NUM_FLAGS-1:0] clr_vec;
  logic [NUM_FLAGS-1:0] status;

  always_comb begin
    set_vec = '0;
    set_vec[BIT_TX_DATA_EMPTY] = ev_tx_data_empty;
    set_vec[BIT_RX_DATA_READY] = ev_rx_data_ready;
    set_vec[BIT_TX_UNDERRUN] = ev_tx_underrun;
    set_vec[BIT_RX_OVERRUN] = ev_rx_overrun;
    set_vec[BIT_RX_CRC_ERROR] = ev_rx_crc_error;
    set_vec[BIT_TX_BUFFER_EMPTY] = ev_tx_buffer_empty;
    set_vec[BIT_RX_BUFFER_FULL] = ev_rx_buffer_full;
    clr_vec = wr_clear ? reg_wdata[NUM_FLAGS-1:0] : '0;
  end

  // Enables never reach the flags themselves [R8]
  swm_flag_bank u_flags (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_pulse(set_vec),
    .clr_pulse(clr_vec),
    .flags(status)
  );

  // Received frame length
  logic [FLEN_W-1:0] frame_len;

  swm_frame_len u_flen (
    .ref_clk(ref_clk),
    .rst(rst),
    .frame_done(rx_frame_done),
    .frame_bytes(rx_frame_bytes),
    .byte_count(frame_len)
  );

  // Interrupt combination
  logic [NUM_FLAGS-1:0] pending;
  logic irq_ff;
  logic nxt_irq;

  always_comb begin
    pending = '0;
    pending[BIT_TX_DATA_EMPTY] = status[BIT_TX_DATA_EMPTY] & enable_ff[BIT_TX_DATA_EMPTY]; // [R1]
    pending[BIT_RX_DATA_READY] = status[BIT_RX_DATA_READY] & enable_ff[BIT_RX_DATA_READY]; // [R2]
    pending[BIT_TX_UNDERRUN] = status[BIT_TX_UNDERRUN] & enable_ff[BIT_TX_UNDERRUN]; // [R3]
    pending[BIT_RX_OVERRUN] = status[BIT_RX_OVERRUN] & enable_ff[BIT_RX_OVERRUN]; // [R4]
    pending[BIT_RX_CRC_ERROR] = status[BIT_RX_CRC_ERROR] & enable_ff[BIT_RX_CRC_ERROR]; // [R5]
    pending[BIT_TX_BUFFER_EMPTY] = status[BIT_TX_BUFFER_EMPTY] & enable_ff[BIT_TX_BUFFER_EMPTY]; // [R6]
    pending[BIT_RX_BUFFER_FULL] = status[BIT_RX_BUFFER_FULL] & enable_ff[BIT_RX_BUFFER_FULL]; // [R7] [R8]
    nxt_irq = |pending; // [R12]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // Valid bytes of the last data word
  logic [VBYTES_W-1:0] tail_ff;
  logic [VBYTES_W-1:0] nxt_tail;

  always_comb begin
    nxt_tail = tail_bytes(frame_len); // [R10]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tail_ff <= '0;
    end else begin
      tail_ff <= nxt_tail;
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = RDATA_UNMAPPED;
    if (rd_any) begin
      if (addr_is(reg_addr, OFF_STATUS)) begin
        nxt_rdata[NUM_FLAGS-1:0] = status;
      end else if (addr_is(reg_addr, OFF_ENABLE)) begin
        nxt_rdata[NUM_FLAGS-1:0] = enable_ff;
      end else if (addr_is(reg_addr, OFF_PENDING)) begin
        nxt_rdata[NUM_FLAGS-1:0] = pending;
      end else if (addr_is(reg_addr, OFF_FRAME_LEN)) begin
        nxt_rdata = RST_FRAME_LEN; // [R11]
        nxt_rdata[FLEN_MSB:FLEN_LSB] = frame_len; // [R9]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= RDATA_UNMAPPED;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign rx_last_word_bytes = tail_ff;

endmodule // swm_irq_frame
`default_nettype wire

// *** rtl/swm_pkg.sv ***
// Package: register map, field positions and reset values of the single-wire master interrupt block
package swm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_FLAGS = 7;
  localparam int FLEN_W = 5;
  localparam int VBYTES_W = 3;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FRAME_LEN = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h1C;

  // Flag and enable bit positions, shared by status, clear, enable and pending
  localparam int BIT_TX_DATA_EMPTY = 6;
  localparam int BIT_RX_DATA_READY = 5;
  localparam int BIT_TX_UNDERRUN = 4;
  localparam int BIT_RX_OVERRUN = 3;
  localparam int BIT_RX_CRC_ERROR = 2;
  localparam int BIT_TX_BUFFER_EMPTY = 1;
  localparam int BIT_RX_BUFFER_FULL = 0;

  // Frame length field
  localparam int FLEN_LSB = 0;
  localparam int FLEN_MSB = 4;
  localparam int FLEN_TAIL_MSB = 1;

  // Reset values
  localparam logic [DATA_W-1:0] RST_FRAME_LEN = 32'h0000_0000;
  localparam logic [NUM_FLAGS-1:0] RST_ENABLE = 7'h00;
  localparam logic [NUM_FLAGS-1:0] RST_FLAGS = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 32'h0000_0000;
  localparam logic [VBYTES_W-1:0] FULL_WORD_BYTES = 3'h4;

endpackage : swm_pkg

// *** tb/swm_irq_frame_asserts.sv ***
// Checker: interrupt and frame length properties at the block ports
`timescale 1ns/10ps
`default_nettype none
module swm_irq_frame_chk
  import swm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic ev_tx_data_empty,
  input wire logic ev_rx_overrun,
  input wire logic ev_rx_buffer_full,
  input wire logic rx_frame_done,
  input wire logic [FLEN_W-1:0] rx_frame_bytes,
  input wire logic irq,
  input wire logic [VBYTES_W-1:0] rx_last_word_bytes
);
  logic [NUM_FLAGS-1:0] en_ff;
  logic [NUM_FLAGS-1:0] nxt_en;
  logic [FLEN_W-1:0] len_ff;
  logic [FLEN_W-1:0] nxt_len;
  logic [VBYTES_W-1:0] tail;
  always_comb begin
    nxt_en = (reg_wr && reg_addr == OFF_ENABLE) ? reg_wdata[NUM_FLAGS-1:0] : en_ff;
    nxt_len = rx_frame_done ? rx_frame_bytes : len_ff;
    tail = (len_ff == 5'h00) ? 3'h0 : ((len_ff[1:0] == 2'h0) ? FULL_WORD_BYTES : {1'b0, len_ff[1:0]});
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_ff <= RST_ENABLE;
      len_ff <= 5'h00;
    end else begin
      en_ff <= nxt_en;
      len_ff <= nxt_len;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_TXE_IRQ: assert property (ev_tx_data_empty ##1 en_ff[BIT_TX_DATA_EMPTY] |=> irq)
    else $error("irq missing for tx data empty");
  AST_OVR_IRQ: assert property (ev_rx_overrun ##1 en_ff[BIT_RX_OVERRUN] |=> irq)
    else $error("irq missing for rx overrun");
  AST_RBF_IRQ: assert property (ev_rx_buffer_full ##1 en_ff[BIT_RX_BUFFER_FULL] |=> irq)
    else $error("irq missing for rx buffer full");
  AST_MASKED: assert property ($past(en_ff) == 7'h00 |-> !irq)
    else $error("irq high with all enables clear");
  AST_HOLD: assert property (irq && !$past(reg_wr) |=> irq)
    else $error("irq dropped without a write");
  AST_LEN_READ: assert property (reg_rd && reg_addr == OFF_FRAME_LEN |=> reg_rdata == {27'h000_0000, $past(len_ff)})
    else $error("frame length read wrong");
  AST_TAIL: assert property (rx_last_word_bytes == $past(tail))
    else $error("valid tail byte count wrong");
  AST_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
endmodule // swm_irq_frame_chk
`default_nettype wire

// *** tb/swm_irq_frame_tb_top.sv ***
// Testbench: register, interrupt and frame length tests
`timescale 1ns/10ps
`default_nettype none
module swm_irq_frame_tb_top
  import swm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_FLAGS-1:0] ev;
  logic rx_frame_done;
  logic [FLEN_W-1:0] rx_frame_bytes;
  logic irq;
  logic [VBYTES_W-1:0] rx_last_word_bytes;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
  swm_irq_frame swm_irq_frame_i (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ev_tx_data_empty(ev[BIT_TX_DATA_EMPTY]), .ev_rx_data_ready(ev[BIT_RX_DATA_READY]),
    .ev_tx_underrun(ev[BIT_TX_UNDERRUN]), .ev_rx_overrun(ev[BIT_RX_OVERRUN]), .ev_rx_crc_error(ev[BIT_RX_CRC_ERROR]),
    .ev_tx_buffer_empty(ev[BIT_TX_BUFFER_EMPTY]), .ev_rx_buffer_full(ev[BIT_RX_BUFFER_FULL]),
    .rx_frame_done, .rx_frame_bytes, .irq, .rx_last_word_bytes);
  swm_link_model swm_link_model_i (.ref_clk, .ev, .rx_frame_done, .rx_frame_bytes);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
    @(posedge ref_clk);
  endtask
  task automatic irq_is(input logic e);
    #1;
    `CHK("irq", e, irq)
    @(posedge ref_clk);
  endtask
  task automatic t_reset();
    irq_is(1'b0);
    rd("len", OFF_FRAME_LEN, RST_FRAME_LEN);
    rd("en", OFF_ENABLE, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_irq();
    for (int i = 0; i < NUM_FLAGS; i++) begin
      wr(OFF_ENABLE, DATA_W'(1) << i);
      swm_link_model_i.pulse(i);
      @(posedge ref_clk);
      irq_is(1'b1);
      rd("sts", OFF_STATUS, DATA_W'(1) << i);
      wr(OFF_CLEAR, DATA_W'(1) << i);
      irq_is(1'b0);
    end
    wr(OFF_ENABLE, 32'h0000_0000);
    swm_link_model_i.pulse(BIT_RX_OVERRUN);
    repeat (2) @(posedge ref_clk);
    irq_is(1'b0);
    rd("sts", OFF_STATUS, 32'h0000_0008);
    rd("pend", OFF_PENDING, 32'h0000_0000);
    wr(OFF_ENABLE, 32'h0000_007F);
    irq_is(1'b1);
    repeat (3) @(posedge ref_clk);
    irq_is(1'b1);
    rd("en", OFF_ENABLE, 32'h0000_007F);
    rd("pend", OFF_PENDING, 32'h0000_0008);
    wr(OFF_CLEAR, 32'h0000_007F);
    irq_is(1'b0);
    // Event and clear of the same flag in one cycle: the event is kept
    fork
      wr(OFF_CLEAR, 32'h0000_0001);
      swm_link_model_i.pulse(BIT_RX_BUFFER_FULL);
    join
    rd("sts", OFF_STATUS, 32'h0000_0001);
    irq_is(1'b1);
    wr(OFF_CLEAR, 32'h0000_0001);
    irq_is(1'b0);
    // Status is read-only, a write leaves it alone
    wr(OFF_STATUS, 32'h0000_007F);
    rd("sts", OFF_STATUS, 32'h0000_0000);
    irq_is(1'b0);
    $display("irq test done");
  endtask
  task automatic t_frame();
    logic [FLEN_W-1:0] n [5] = '{5'h00, 5'h06, 5'h07, 5'h1F, 5'h04};
    logic [VBYTES_W-1:0] v [5] = '{3'h0, 3'h2, 3'h3, 3'h3, 3'h4};
    for (int i = 0; i < 5; i++) begin
      swm_link_model_i.frame(n[i]);
      @(posedge ref_clk);
      #1;
      `CHK("tail", v[i], rx_last_word_bytes)
      @(posedge ref_clk);
      rd("len", OFF_FRAME_LEN, DATA_W'(n[i]));
    end
    wr(OFF_FRAME_LEN, 32'h0000_001F);
    rd("len", OFF_FRAME_LEN, 32'h0000_0004);
    rd("free", 8'h40, RDATA_UNMAPPED);
    $display("frame test done");
  endtask
  // Reset in mid-run with an enabled flag set and a frame length held
  task automatic t_rerun();
    wr(OFF_ENABLE, 32'h0000_007F);
    swm_link_model_i.pulse(BIT_TX_UNDERRUN);
    repeat (2) @(posedge ref_clk);
    irq_is(1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("tail", 3'h0, rx_last_word_bytes)
    irq_is(1'b0);
    rd("sts", OFF_STATUS, 32'h0000_0000);
    rd("len", OFF_FRAME_LEN, RST_FRAME_LEN);
    rd("en", OFF_ENABLE, 32'h0000_0000);
    $display("reset again test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_irq();
    t_frame();
    t_rerun();
    test_done();
  end
endmodule // swm_irq_frame_tb_top
bind swm_irq_frame swm_irq_frame_chk swm_irq_frame_chk_i (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .ev_tx_data_empty, .ev_rx_overrun, .ev_rx_buffer_full, .rx_frame_done, .rx_frame_bytes, .irq,
  .rx_last_word_bytes);
`default_nettype wire

// *** tb/swm_link_model.sv ***
// Partner: link logic model giving event pulses and frame completions
`timescale 1ns/10ps
`default_nettype none
module swm_link_model
  import swm_pkg::*;
(
  input wire logic ref_clk,
  output logic [NUM_FLAGS-1:0] ev,
  output logic rx_frame_done,
  output logic [FLEN_W-1:0] rx_frame_bytes
);
  initial begin
    ev = 7'h00;
    rx_frame_done = 1'b0;
    rx_frame_bytes = 5'h00;
  end
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask
  // Count only holds beside the done pulse, then flips
  task automatic frame(input logic [FLEN_W-1:0] n);
    rx_frame_done <= 1'b1;
    rx_frame_bytes <= n;
    @(posedge ref_clk);
    rx_frame_done <= 1'b0;
    rx_frame_bytes <= ~n;
  endtask
endmodule // swm_link_model
`default_nettype wire
